// file: rtl/timer_ctrl.sv
// Timer channel mode, forced compare, main counter and system control with APB slave
//
// The APB register port was chosen for this implementation.
`include "timer_ctrl_params.svh"

module timer_ctrl #(
  parameter int CHANNELS = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic wait_mode,
  input wire logic freeze_mode,
  input wire logic [CHANNELS-1:0] capture_event,
  output logic [CHANNELS-1:0] compare_output_line,
  output logic [CHANNELS-1:0] channel_event_flag,
  output logic counter_wrap_flag,
  output timer_ctrl_pkg::count_t counter_value,
  output logic prescale_tick,
  output logic accumulator_tick
);
  import timer_ctrl_pkg::*;

  // Control and status state
  logic [CHANNELS-1:0] dir_select_reg;
  logic [CHANNELS-1:0] toggle_wrap_reg;
  logic [2*CHANNELS-1:0] oc_ctrl_reg;
  logic run_enable_reg;
  logic stop_in_wait_reg;
  logic stop_in_freeze_reg;
  logic fast_flag_clear_reg;
  logic precision_select_reg;
  logic precision_locked_reg;
  logic [2:0] legacy_prescale_reg;
  logic [7:0] precision_prescale_reg;
  count_t counter_reg;
  count_t channel_value_reg [CHANNELS];
  logic [CHANNELS-1:0] flag_reg;
  logic wrap_flag_reg;
  logic [CHANNELS-1:0] line_reg;
  logic [7:0] presc_cnt_reg;
  logic presc_tick_reg;
  logic [5:0] acc_cnt_reg;
  logic acc_tick_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // Bus decode
  reg_index_t idx;
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic addr_ok;

  assign idx = paddr[7:2];
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_reg;
  assign wr_done = access_done && pwrite && addr_ok;
  assign rd_done = access_done && !pwrite && addr_ok;

  function automatic logic is_channel_idx(input reg_index_t i, input int ch);
    is_channel_idx = (i == (`IDX_CHANNEL_BASE + reg_index_t'(2 * ch)));
  endfunction

  function automatic logic is_mapped(input reg_index_t i);
    logic hit;
    hit = 1'b0;
    for (int c = 0; c < CHANNELS; c++) begin
      if (is_channel_idx(i, c)) begin
        hit = 1'b1;
      end
    end
    unique case (i)
      `IDX_DIR_SELECT, `IDX_COMPARE_FORCE, `IDX_COUNTER, `IDX_COUNTER_LOW,
      `IDX_SYS_CTRL_ONE, `IDX_TOGGLE_WRAP, `IDX_OC_CTRL_HIGH, `IDX_OC_CTRL_LOW,
      `IDX_SYS_CTRL_TWO, `IDX_CHANNEL_FLAGS, `IDX_WRAP_FLAG,
      `IDX_PRECISION_PRESCALE: is_mapped = 1'b1;
      default: is_mapped = hit;
    endcase
  endfunction

  function automatic logic oc_apply(input logic cur, input oc_action_t act);
    unique case (act)
      OC_NONE: oc_apply = cur;
      OC_TOGGLE: oc_apply = !cur;
      OC_CLEAR: oc_apply = 1'b0;
      OC_SET: oc_apply = 1'b1;
    endcase
  endfunction

  assign addr_ok = is_mapped(idx) && (paddr[1:0] == 2'b00);

  // Run qualifiers
  logic timer_active;
  logic counter_run;
  logic [7:0] presc_last;
  logic tick_now;
  logic cnt_adv;
  logic wrap_now;
  logic cnt_write;
  count_t cnt_inc;

  assign timer_active = run_enable_reg && !(wait_mode && stop_in_wait_reg);
  assign counter_run = timer_active && !(freeze_mode && stop_in_freeze_reg);
  assign presc_last = precision_select_reg ? precision_prescale_reg :
                      8'((9'h001 << legacy_prescale_reg) - 9'h001);
  assign tick_now = timer_active && (presc_cnt_reg == presc_last);
  assign cnt_adv = tick_now && counter_run;
  assign cnt_inc = counter_reg + 16'h0001;
  assign wrap_now = cnt_adv && (counter_reg == 16'hFFFF);
  assign cnt_write = wr_done && (idx == `IDX_COUNTER) && special_mode;

  // Prescaler; a counter write does not realign it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_reg <= `RST_PRESCALE;
      presc_tick_reg <= 1'b0;
    end else begin
      presc_tick_reg <= tick_now;
      if (!timer_active) begin
        presc_cnt_reg <= presc_cnt_reg;
      end else if (tick_now || presc_cnt_reg > presc_last) begin
        presc_cnt_reg <= `RST_PRESCALE;
      end else begin
        presc_cnt_reg <= presc_cnt_reg + 8'h01;
      end
    end
  end

  // Divide by 64 accumulator clock, only while timer active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_cnt_reg <= 6'h00;
      acc_tick_reg <= 1'b0;
    end else begin
      acc_tick_reg <= timer_active && (acc_cnt_reg == `ACC_DIV_LAST);
      if (timer_active) begin
        acc_cnt_reg <= acc_cnt_reg + 6'h01;
      end
    end
  end

  // Main counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_reg <= `RST_COUNTER;
    end else if (cnt_write) begin
      counter_reg <= pwdata[15:0];
    end else if (cnt_adv) begin
      counter_reg <= cnt_inc;
    end
  end

  // Wrap flag; set beats clear
  logic wrap_clr;
  assign wrap_clr = (wr_done && idx == `IDX_WRAP_FLAG && !fast_flag_clear_reg &&
                     pwdata[`BIT_WRAP_FLAG]) ||
                    (fast_flag_clear_reg && access_done && addr_ok &&
                     (idx == `IDX_COUNTER || idx == `IDX_COUNTER_LOW));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_flag_reg <= 1'b0;
    end else begin
      wrap_flag_reg <= wrap_now || (wrap_flag_reg && !wrap_clr);
    end
  end

  // System control one; precision select is writable once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_enable_reg <= 1'b0;
      stop_in_wait_reg <= 1'b0;
      stop_in_freeze_reg <= 1'b0;
      fast_flag_clear_reg <= 1'b0;
      precision_select_reg <= 1'b0;
      precision_locked_reg <= 1'b0;
    end else if (wr_done && idx == `IDX_SYS_CTRL_ONE) begin
      run_enable_reg <= pwdata[`BIT_RUN_ENABLE];
      stop_in_wait_reg <= pwdata[`BIT_STOP_IN_WAIT];
      stop_in_freeze_reg <= pwdata[`BIT_STOP_IN_FREEZE];
      fast_flag_clear_reg <= pwdata[`BIT_FAST_FLAG_CLEAR];
      precision_locked_reg <= 1'b1;
      if (!precision_locked_reg) begin
        precision_select_reg <= pwdata[`BIT_PRECISION_SELECT];
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_select_reg <= '0;
      toggle_wrap_reg <= '0;
      oc_ctrl_reg <= '0;
      legacy_prescale_reg <= 3'h0;
      precision_prescale_reg <= `RST_PRESCALE;
    end else if (wr_done) begin
      unique case (idx)
        `IDX_DIR_SELECT: dir_select_reg <= pwdata[CHANNELS-1:0];
        `IDX_TOGGLE_WRAP: toggle_wrap_reg <= pwdata[CHANNELS-1:0];
        `IDX_OC_CTRL_LOW: oc_ctrl_reg[7:0] <= pwdata[7:0];
        `IDX_OC_CTRL_HIGH: oc_ctrl_reg[2*CHANNELS-1:8] <= pwdata[2*CHANNELS-9:0];
        `IDX_SYS_CTRL_TWO: legacy_prescale_reg <= pwdata[2:0];
        `IDX_PRECISION_PRESCALE: precision_prescale_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Per channel compare, capture, force and flag logic
  logic [CHANNELS-1:0] force_now;
  logic [CHANNELS-1:0] match_hit;

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic cap_now;
    logic flag_set;
    logic flag_clr;
    logic val_write;
    oc_action_t act;

    assign act = oc_action_t'(oc_ctrl_reg[2*ch+1:2*ch]);
    assign force_now[ch] = wr_done && idx == `IDX_COMPARE_FORCE && pwdata[ch] &&
                           dir_select_reg[ch];
    assign match_hit[ch] = dir_select_reg[ch] && cnt_adv &&
                           (cnt_inc == channel_value_reg[ch]);
    assign cap_now = !dir_select_reg[ch] && timer_active && capture_event[ch];
    assign val_write = wr_done && is_channel_idx(idx, ch);
    assign flag_set = (match_hit[ch] && !force_now[ch]) || cap_now;
    assign flag_clr = (wr_done && idx == `IDX_CHANNEL_FLAGS && !fast_flag_clear_reg &&
                       pwdata[ch]) ||
                      (fast_flag_clear_reg && access_done && addr_ok &&
                       is_channel_idx(idx, ch) &&
                       (pwrite == dir_select_reg[ch]));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_reg[ch] <= 1'b0;
      end else begin
        flag_reg[ch] <= flag_set || (flag_reg[ch] && !flag_clr);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        channel_value_reg[ch] <= `RST_COUNTER;
      end else if (cap_now) begin
        channel_value_reg[ch] <= counter_reg;
      end else if (val_write) begin
        channel_value_reg[ch] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        line_reg[ch] <= 1'b0;
      end else if (wrap_now && toggle_wrap_reg[ch] && dir_select_reg[ch]) begin
        line_reg[ch] <= !line_reg[ch];
      end else if (force_now[ch] || match_hit[ch]) begin
        line_reg[ch] <= oc_apply(line_reg[ch], act);
      end
    end
  end

  // Read mux, unused bits read zero
  function automatic logic [31:0] read_value(input reg_index_t i);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (i)
      `IDX_DIR_SELECT: v[CHANNELS-1:0] = dir_select_reg;
      `IDX_COMPARE_FORCE: v = 32'h0000_0000;
      `IDX_COUNTER: v[15:0] = counter_reg;
      `IDX_COUNTER_LOW: v[7:0] = counter_reg[7:0];
      `IDX_SYS_CTRL_ONE: v[7:3] = {run_enable_reg, stop_in_wait_reg, stop_in_freeze_reg,
                                   fast_flag_clear_reg, precision_select_reg};
      `IDX_TOGGLE_WRAP: v[CHANNELS-1:0] = toggle_wrap_reg;
      `IDX_OC_CTRL_LOW: v[7:0] = oc_ctrl_reg[7:0];
      `IDX_OC_CTRL_HIGH: v[2*CHANNELS-9:0] = oc_ctrl_reg[2*CHANNELS-1:8];
      `IDX_SYS_CTRL_TWO: v[2:0] = legacy_prescale_reg;
      `IDX_CHANNEL_FLAGS: v[CHANNELS-1:0] = flag_reg;
      `IDX_WRAP_FLAG: v[`BIT_WRAP_FLAG] = wrap_flag_reg;
      `IDX_PRECISION_PRESCALE: v[7:0] = precision_prescale_reg;
      default: begin
        for (int c = 0; c < CHANNELS; c++) begin
          if (is_channel_idx(i, c)) begin
            v[15:0] = channel_value_reg[c];
          end
        end
      end
    endcase
    return v;
  endfunction

  // APB slave: one wait-free access phase, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !addr_ok;
      if (setup_phase && !pwrite && addr_ok) begin
        prdata_reg <= read_value(idx);
      end else if (setup_phase) begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign compare_output_line = line_reg;
  assign channel_event_flag = flag_reg;
  assign counter_wrap_flag = wrap_flag_reg;
  assign counter_value = counter_reg;
  assign prescale_tick = presc_tick_reg;
  assign accumulator_tick = acc_tick_reg;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_read_setup(reg_index_t i);
    setup_phase && !pwrite && idx == i && paddr[1:0] == 2'b00;
  endsequence

  sequence s_force_ch0;
    wr_done && idx == `IDX_COMPARE_FORCE && pwdata[0] && dir_select_reg[0] &&
    !(wrap_now && toggle_wrap_reg[0]);
  endsequence

  property p_missing_bits_zero;
    s_read_setup(`IDX_DIR_SELECT) |=> prdata[31:CHANNELS] == '0;
  endproperty
  a_missing_bits_zero: assert property (p_missing_bits_zero)
    else $error("missing channel bits read nonzero");

  property p_force_reads_zero;
    s_read_setup(`IDX_COMPARE_FORCE) |=> pready && prdata == 32'h0000_0000;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("compare force register read nonzero");

  property p_force_sets_high;
    s_force_ch0 ##0 (oc_ctrl_reg[1:0] == 2'b11) |=> compare_output_line[0];
  endproperty
  a_force_sets_high: assert property (p_force_sets_high)
    else $error("forced set action did not drive line high");

  property p_force_no_flag;
    s_force_ch0 ##0 !flag_reg[0] |=> !channel_event_flag[0];
  endproperty
  a_force_no_flag: assert property (p_force_no_flag)
    else $error("forced compare set the channel flag");

  property p_counter_locked;
    wr_done && idx == `IDX_COUNTER && !special_mode && !cnt_adv |=> $stable(counter_value);
  endproperty
  a_counter_locked: assert property (p_counter_locked)
    else $error("counter written outside special mode");

  property p_disabled_still;
    !run_enable_reg && !cnt_write |=> $stable(counter_value) && !prescale_tick;
  endproperty
  a_disabled_still: assert property (p_disabled_still)
    else $error("counter moved while timer disabled");

  property p_freeze_still;
    freeze_mode && stop_in_freeze_reg && !cnt_write |=> $stable(counter_value);
  endproperty
  a_freeze_still: assert property (p_freeze_still)
    else $error("counter moved in freeze with stop set");

  property p_wrap;
    counter_reg == 16'hFFFF && cnt_adv && !cnt_write |=>
      counter_value == 16'h0000 && counter_wrap_flag;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter wrap did not clear count and set flag");

  property p_precision_once;
    precision_locked_reg && wr_done && idx == `IDX_SYS_CTRL_ONE |=>
      $stable(precision_select_reg);
  endproperty
  a_precision_once: assert property (p_precision_once)
    else $error("precision select changed after first write");

  property p_acc_absent;
    !timer_active |=> !accumulator_tick;
  endproperty
  a_acc_absent: assert property (p_acc_absent)
    else $error("accumulator tick while timer inactive");

endmodule

// file: rtl/timer_ctrl_params.svh
// Register indices, field positions and reset values for the timer control block
`ifndef TIMER_CTRL_PARAMS_SVH
`define TIMER_CTRL_PARAMS_SVH
// Register indices; byte address is four times the index
`define IDX_DIR_SELECT 6'h00
`define IDX_COMPARE_FORCE 6'h01
`define IDX_COUNTER 6'h04
`define IDX_COUNTER_LOW 6'h05
`define IDX_SYS_CTRL_ONE 6'h06
`define IDX_TOGGLE_WRAP 6'h07
`define IDX_OC_CTRL_HIGH 6'h08
`define IDX_OC_CTRL_LOW 6'h09
`define IDX_SYS_CTRL_TWO 6'h0D
`define IDX_CHANNEL_FLAGS 6'h0E
`define IDX_WRAP_FLAG 6'h0F
`define IDX_CHANNEL_BASE 6'h10
`define IDX_PRECISION_PRESCALE 6'h2E
// System control one fields
`define BIT_RUN_ENABLE 7
`define BIT_STOP_IN_WAIT 6
`define BIT_STOP_IN_FREEZE 5
`define BIT_FAST_FLAG_CLEAR 4
`define BIT_PRECISION_SELECT 3
// Wrap flag position
`define BIT_WRAP_FLAG 7
// Reset values
`define RST_CTRL8 8'h00
`define RST_COUNTER 16'h0000
`define RST_PRESCALE 8'h00
// Pulse accumulator divider
`define ACC_DIV_LAST 6'h3F
`endif

// file: rtl/timer_ctrl_pkg.sv
// Types shared by the timer control block
package timer_ctrl_pkg;
  typedef logic [15:0] count_t;
  typedef logic [5:0] reg_index_t;
  typedef enum logic [1:0] {
    OC_NONE = 2'b00,
    OC_TOGGLE = 2'b01,
    OC_CLEAR = 2'b10,
    OC_SET = 2'b11
  } oc_action_t;
endpackage

// file: verif/tb.sv
// Self-checking bench for the timer control block
`include "timer_ctrl_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, special_mode, wait_mode, freeze_mode;
  logic [5:0] capture_event, compare_output_line, channel_event_flag;
  logic counter_wrap_flag, prescale_tick, accumulator_tick;
  timer_ctrl_pkg::count_t counter_value;
  int miscompares, n_tests, ch, nt;
  logic [31:0] rd, pw;
  logic err;
  logic [1:0] code;
  logic [5:0] line_exp;
  logic [15:0] cv;

  timer_ctrl #(.CHANNELS(6)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_mode(special_mode), .wait_mode(wait_mode), .freeze_mode(freeze_mode),
    .capture_event(capture_event), .compare_output_line(compare_output_line),
    .channel_event_flag(channel_event_flag), .counter_wrap_flag(counter_wrap_flag),
    .counter_value(counter_value), .prescale_tick(prescale_tick),
    .accumulator_tick(accumulator_tick)
  );

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask

  // One APB transfer; waits on pready with a bound
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask

  // Counter must move by step over n cycles
  task automatic run_chk(input string what, input int n, input int step);
    timer_ctrl_pkg::count_t c0;
    @(posedge pclk);
    #1;
    c0 = counter_value;
    repeat (n) @(posedge pclk);
    #1;
    chk(what, {16'h0, c0 + 16'(step)}, {16'h0, counter_value});
  endtask

  task automatic acc_chk(input string what, input logic want);
    int k;
    k = 0;
    repeat (130) begin
      @(posedge pclk);
      #1;
      if (accumulator_tick === 1'b1) k++;
    end
    chk(what, {31'h0, want}, {31'h0, k > 0});
  endtask

  function automatic logic act(input logic cur, input logic [1:0] c);
    case (c)
      2'b00: act = cur;
      2'b01: act = ~cur;
      2'b10: act = 1'b0;
      default: act = 1'b1;
    endcase
  endfunction

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    special_mode = 1'b0;
    wait_mode = 1'b0;
    freeze_mode = 1'b0;
    capture_event = 6'h00;
    line_exp = 6'h00;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(9));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("dir reset", `IDX_DIR_SELECT, 32'h0);
    rdchk("ctrl reset", `IDX_SYS_CTRL_ONE, 32'h0);
    rdchk("counter reset", `IDX_COUNTER, 32'h0);
    repeat (6) begin
      pw = $urandom;
      wr(`IDX_DIR_SELECT, pw);
      rdchk("dir", `IDX_DIR_SELECT, pw & 32'h3F);
    end
    wr(`IDX_COMPARE_FORCE, 32'hFF);
    rdchk("force read", `IDX_COMPARE_FORCE, 32'h0);
    apb(1'b0, 6'h03, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    wr(`IDX_SYS_CTRL_ONE, 32'h08);
    wr(`IDX_SYS_CTRL_ONE, 32'h00);
    rdchk("precision lock", `IDX_SYS_CTRL_ONE, 32'h08);
    run_chk("halted", 20, 0);
    acc_chk("acc off", 1'b0);
    wr(`IDX_COUNTER, 32'h0000FFF0);
    rdchk("normal write", `IDX_COUNTER, 32'h0);
    special_mode <= 1'b1;
    wr(`IDX_COUNTER, 32'h0000FFF0);
    rdchk("special write", `IDX_COUNTER, 32'hFFF0);
    special_mode <= 1'b0;
    wr(`IDX_SYS_CTRL_ONE, 32'h80);
    rdchk("ctrl one", `IDX_SYS_CTRL_ONE, 32'h88);
    run_chk("count up", 10, 10);
    repeat (20) @(posedge pclk);
    rdchk("wrap flag", `IDX_WRAP_FLAG, 32'h80);
    acc_chk("acc on", 1'b1);
    wr(`IDX_SYS_CTRL_ONE, 32'h90);
    apb(1'b0, `IDX_COUNTER, 32'h0);
    rdchk("fast wrap clear", `IDX_WRAP_FLAG, 32'h0);
    wr(`IDX_SYS_CTRL_ONE, 32'hC0);
    wait_mode <= 1'b1;
    run_chk("wait halt", 20, 0);
    acc_chk("wait acc", 1'b0);
    @(posedge pclk) wait_mode <= 1'b0;
    wr(`IDX_SYS_CTRL_ONE, 32'hA0);
    freeze_mode <= 1'b1;
    run_chk("freeze halt", 20, 0);
    acc_chk("freeze acc", 1'b1);
    wr(`IDX_SYS_CTRL_ONE, 32'h80);
    run_chk("freeze run", 10, 10);
    @(posedge pclk) freeze_mode <= 1'b0;
    wr(`IDX_DIR_SELECT, 32'h3F);
    wr(`IDX_CHANNEL_FLAGS, 32'h3F);
    for (int i = 0; i < 8; i++) begin
      ch = $urandom_range(5);
      code = 2'(i);
      if (ch > 3) begin
        wr(`IDX_OC_CTRL_HIGH, 32'(code) << (2 * (ch - 4)));
      end else begin
        wr(`IDX_OC_CTRL_LOW, 32'(code) << (2 * ch));
      end
      wr(`IDX_COMPARE_FORCE, 32'h1 << ch);
      line_exp[ch] = act(line_exp[ch], code);
      #1;
      chk("force line", {31'h0, line_exp[ch]}, {31'h0, compare_output_line[ch]});
      chk("force flag", 32'h0, {31'h0, channel_event_flag[ch]});
    end
    // Channel one toggles on a real match
    wr(`IDX_OC_CTRL_LOW, 32'h4);
    wr(`IDX_CHANNEL_BASE + 6'd2, {16'h0, counter_value + 16'd30});
    ch = 0;
    while (channel_event_flag[1] !== 1'b1 && ch < 60) begin
      @(posedge pclk);
      ch++;
    end
    #1;
    chk("match flag", 32'h1, {31'h0, channel_event_flag[1]});
    chk("match line", {31'h0, ~line_exp[1]}, {31'h0, compare_output_line[1]});
    wr(`IDX_SYS_CTRL_ONE, 32'h90);
    wr(`IDX_CHANNEL_BASE + 6'd2, {16'h0, counter_value + 16'd1000});
    apb(1'b0, `IDX_CHANNEL_FLAGS, 32'h0);
    chk("fast chan clear", 32'h0, rd & 32'h2);
    // Force lands on the edge of a real match on channel zero
    wr(`IDX_OC_CTRL_LOW, 32'h3);
    wr(`IDX_CHANNEL_BASE, 32'h1003);
    special_mode <= 1'b1;
    wr(`IDX_COUNTER, 32'h1000);
    special_mode <= 1'b0;
    wr(`IDX_COMPARE_FORCE, 32'h1);
    line_exp[0] = 1'b1;
    #1;
    chk("force match line", 32'h1, {31'h0, compare_output_line[0]});
    chk("force match flag", 32'h0, {31'h0, channel_event_flag[0]});
    // Toggle on wrap for channel three
    wr(`IDX_TOGGLE_WRAP, 32'h8);
    special_mode <= 1'b1;
    wr(`IDX_COUNTER, 32'hFFF0);
    special_mode <= 1'b0;
    repeat (30) @(posedge pclk);
    #1;
    chk("wrap toggle", {31'h0, ~line_exp[3]}, {31'h0, compare_output_line[3]});
    chk("wrap flag out", 32'h1, {31'h0, counter_wrap_flag});
    wr(`IDX_PRECISION_PRESCALE, 32'h4);
    run_chk("precision prescale", 50, 10);
    // Second reset in mid run
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk("mid reset outs", 32'h0, {3'h0, compare_output_line, channel_event_flag,
                                  counter_wrap_flag, counter_value});
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(`IDX_SYS_CTRL_TWO, 32'h2);
    wr(`IDX_SYS_CTRL_ONE, 32'h90);
    rdchk("legacy ctrl", `IDX_SYS_CTRL_ONE, 32'h90);
    nt = 0;
    repeat (40) begin
      @(posedge pclk);
      #1;
      if (prescale_tick === 1'b1) nt++;
    end
    chk("legacy ticks", 32'hA, nt);
    run_chk("legacy prescale", 40, 10);
    // Input capture on channel two
    @(posedge pclk);
    capture_event <= 6'h04;
    #1;
    cv = counter_value;
    @(posedge pclk);
    capture_event <= 6'h00;
    rdchk("capture flag", `IDX_CHANNEL_FLAGS, 32'h4);
    rdchk("capture value", `IDX_CHANNEL_BASE + 6'h4, {16'h0, cv});
    rdchk("capture fast clear", `IDX_CHANNEL_FLAGS, 32'h0);
    report_and_stop();
  end
endmodule
